// file: hdl/peiu_defines.svh
`ifndef PEIU_DEFINES_SVH
`define PEIU_DEFINES_SVH

// Management register port geometry.
`define PEIU_ADDR_W 5
`define PEIU_DATA_W 16

// Management register addresses.
`define PEIU_ADDR_STATUS 5'h14
`define PEIU_ADDR_MASK 5'h15
`define PEIU_ADDR_CLEAR 5'h17

// Reset values and the implemented event bits; bits 2:0 are reserved.
`define PEIU_STATUS_RESET 16'h0000
`define PEIU_MASK_RESET 16'h0000
`define PEIU_READ_ZERO 16'h0000
`define PEIU_EVENT_BITS 16'hFFF8

// Event bit positions, shared by the flag and the enable words.
`define PEIU_BIT_SPEED 15
`define PEIU_BIT_LINK 14
`define PEIU_BIT_DUPLEX 13
`define PEIU_BIT_MDIX 12
`define PEIU_BIT_POLARITY 11
`define PEIU_BIT_PAR_FAULT 10
`define PEIU_BIT_MS_ERROR 9
`define PEIU_BIT_NO_HCD 8
`define PEIU_BIT_NO_LINK 7
`define PEIU_BIT_JABBER 6
`define PEIU_BIT_NEXT_PAGE 5
`define PEIU_BIT_AN_DONE 4
`define PEIU_BIT_REM_FAULT 3

// Timing: core clock rate and the wait for link after negotiation.
`define PEIU_CLK_MHZ 125
`define PEIU_NO_LINK_WAIT_US 1000
`define PEIU_NO_LINK_CYCLES (`PEIU_NO_LINK_WAIT_US * `PEIU_CLK_MHZ)
`define PEIU_TIMER_W 24

`endif

// file: hdl/peiu_pkg.sv
package peiu_pkg;

`include "peiu_defines.svh"

    // Resolved link speed as reported by the negotiation logic.
    typedef enum logic [1:0] {
        PEIU_SPEED_10 = 2'h0,
        PEIU_SPEED_100 = 2'h1,
        PEIU_SPEED_1000 = 2'h2,
        PEIU_SPEED_RSVD = 2'h3
    } peiu_speed_type;

    // Watch for link after negotiation has completed.
    typedef enum logic [2:0] {
        PEIU_NL_IDLE = 3'b001,
        PEIU_NL_WAIT = 3'b010,
        PEIU_NL_HOLD = 3'b100
    } peiu_nl_state_type;

    // State of the control and detection module.
    typedef struct packed {
        logic armed;
        peiu_speed_type speed_prev;
        logic link_prev;
        logic duplex_prev;
        logic mdix_prev;
        logic [3:0] pol_prev;
        logic pdf_prev;
        logic msf_prev;
        logic nohcd_prev;
        logic jab_prev;
        logic np_prev;
        logic an_prev;
        logic rf_prev;
        peiu_nl_state_type nl_state;
        logic [`PEIU_TIMER_W-1:0] nl_timer;
        logic [`PEIU_DATA_W-1:0] rd_data;
        logic rd_valid;
    } peiu_ctrl_state_type;

    // State of the flag and enable bank.
    typedef struct packed {
        logic [`PEIU_DATA_W-1:0] flags;
        logic [`PEIU_DATA_W-1:0] mask;
        logic irq;
    } peiu_bank_state_type;

endpackage : peiu_pkg

// file: hdl/peiu_flag_if.sv
`timescale 1ns/100ps
`include "peiu_defines.svh"

// Carries events, clears and enable updates between detection and the bank.
interface peiu_flag_if;
    logic [`PEIU_DATA_W-1:0] event_set;
    logic [`PEIU_DATA_W-1:0] clear_req;
    logic mask_we;
    logic [`PEIU_DATA_W-1:0] mask_wdata;
    logic [`PEIU_DATA_W-1:0] flags;
    logic [`PEIU_DATA_W-1:0] mask;
    logic irq;

    modport bank (
        input event_set,
        input clear_req,
        input mask_we,
        input mask_wdata,
        output flags,
        output mask,
        output irq
    );

    modport ctrl (
        output event_set,
        output clear_req,
        output mask_we,
        output mask_wdata,
        input flags,
        input mask,
        input irq
    );
endinterface : peiu_flag_if

// file: hdl/peiu_flag_bank.sv
`timescale 1ns/100ps
`include "peiu_defines.svh"

module peiu_flag_bank (
    input wire logic clk,
    input wire logic rst_n,
    peiu_flag_if.bank fb
);

    peiu_pkg::peiu_bank_state_type state_reg;
    peiu_pkg::peiu_bank_state_type state_next;
    logic [`PEIU_DATA_W-1:0] clear_eff;

    // Flags are sticky; a new event in the clear cycle survives the clear.
    always_comb
    begin
        state_next = state_reg;
        clear_eff = fb.clear_req & `PEIU_EVENT_BITS;
        state_next.flags = (state_reg.flags & ~clear_eff)
            | (fb.event_set & `PEIU_EVENT_BITS);
        if (fb.mask_we)
        begin
            state_next.mask = fb.mask_wdata & `PEIU_EVENT_BITS;
        end
        // The output follows the new flags in the same edge they are set.
        state_next.irq = |(state_next.flags & state_next.mask);
    end

    // Registers the bank; all flags and enables clear on reset.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.flags <= `PEIU_STATUS_RESET;
            state_reg.mask <= `PEIU_MASK_RESET;
            state_reg.irq <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign fb.flags = state_reg.flags;
    assign fb.mask = state_reg.mask;
    assign fb.irq = state_reg.irq;

endmodule : peiu_flag_bank

// file: hdl/peiu_top.sv
`timescale 1ns/100ps
`include "peiu_defines.svh"

module peiu_top #(
    parameter int unsigned NO_LINK_CYCLES = `PEIU_NO_LINK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    // Management register port.
    input wire logic [`PEIU_ADDR_W-1:0] mgmt_addr,
    input wire logic mgmt_wr_en,
    input wire logic [`PEIU_DATA_W-1:0] mgmt_wr_data,
    input wire logic mgmt_rd_en,
    output logic [`PEIU_DATA_W-1:0] mgmt_rd_data,
    output logic mgmt_rd_valid,
    // Link status from the transceiver core.
    input wire logic [1:0] link_speed,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic mdix_swapped,
    input wire logic [3:0] rx_polarity,
    input wire logic par_det_fault,
    input wire logic ms_cfg_fault,
    input wire logic no_common_ability,
    input wire logic jabber_active,
    input wire logic next_page_rx,
    input wire logic an_done,
    input wire logic remote_fault,
    // Interrupt to the station, active high.
    output logic irq
);

    // Last count of the link watch. The wait ends one count early so that
    // the flag lands exactly NO_LINK_CYCLES edges after negotiation is done.
    // A wait longer than the timer can hold is cut to its low bits, so the
    // parameter must stay within the timer width.
    localparam logic [`PEIU_TIMER_W-1:0] NL_LIMIT = `PEIU_TIMER_W'(NO_LINK_CYCLES - 1);

    // Control state: input history, the link watch and the read answer.
    peiu_pkg::peiu_ctrl_state_type state_reg;
    peiu_pkg::peiu_ctrl_state_type state_next;

    // Decoded inputs and the words handed to the bank each cycle.
    peiu_pkg::peiu_speed_type speed_now;
    logic [`PEIU_DATA_W-1:0] events;
    logic [`PEIU_DATA_W-1:0] clear_bits;
    logic mask_wr;
    logic no_link_hit;
    logic is_1000;
    logic is_10;

    // Carries events, clears and enable updates over to the bank.
    peiu_flag_if fif ();

    // Flag and enable storage with the interrupt output.
    peiu_flag_bank u_bank (
        .clk(clk),
        .rst_n(rst_n),
        .fb(fif.bank)
    );

    // Speed decode. The reserved code counts as neither 10 nor 1000 Mb/s,
    // so while it stands both the jabber and the master/slave events are held off.
    assign speed_now = peiu_pkg::peiu_speed_type'(link_speed);
    assign is_1000 = (speed_now == peiu_pkg::PEIU_SPEED_1000);
    assign is_10 = (speed_now == peiu_pkg::PEIU_SPEED_10);

    // Management writes: the clear word only pulses for the write cycle,
    // so it reads back as zero and never needs a second write to release.
    // A read in the same cycle as a write sees the word before the write.
    always_comb
    begin
        clear_bits = `PEIU_READ_ZERO;
        mask_wr = 1'b0;
        if (mgmt_wr_en && (mgmt_addr == `PEIU_ADDR_MASK))
        begin
            mask_wr = 1'b1;
        end
        else if (mgmt_wr_en && (mgmt_addr == `PEIU_ADDR_CLEAR))
        begin
            clear_bits = mgmt_wr_data;
        end
        else
        begin
            // Writes elsewhere, the read-only flag word included, are dropped.
            clear_bits = `PEIU_READ_ZERO;
        end
    end

    // Event detection. Nothing is flagged until the first sample after
    // reset has been taken, otherwise inputs that already stand at one
    // would look like changes from the reset value of the history.
    // Each event is a one-cycle pulse; the bank holds it as a flag.
    always_comb
    begin
        events = `PEIU_READ_ZERO;
        if (state_reg.armed)
        begin
            // Changes of link state count on either edge.
            events[`PEIU_BIT_SPEED] = (speed_now != state_reg.speed_prev);
            events[`PEIU_BIT_LINK] = (link_up != state_reg.link_prev);
            events[`PEIU_BIT_DUPLEX] = (full_duplex != state_reg.duplex_prev);
            events[`PEIU_BIT_MDIX] = (mdix_swapped != state_reg.mdix_prev);
            events[`PEIU_BIT_POLARITY] = (rx_polarity != state_reg.pol_prev);

            // Fault reports are levels; only their rising edge is an event.
            events[`PEIU_BIT_PAR_FAULT] = par_det_fault && !state_reg.pdf_prev;
            events[`PEIU_BIT_MS_ERROR] = ms_cfg_fault && !state_reg.msf_prev
                && is_1000;
            events[`PEIU_BIT_NO_HCD] = no_common_ability && !state_reg.nohcd_prev;

            // The link watch below decides when no link has followed negotiation.
            events[`PEIU_BIT_NO_LINK] = no_link_hit;

            // Jabber is only meaningful at 10 Mb/s; both edges count there.
            events[`PEIU_BIT_JABBER] = (jabber_active != state_reg.jab_prev)
                && is_10;

            // Next page and negotiation done count on their rising edge only, so a
            // level that the core holds high is reported once and not every cycle.
            events[`PEIU_BIT_NEXT_PAGE] = next_page_rx && !state_reg.np_prev;
            events[`PEIU_BIT_AN_DONE] = an_done && !state_reg.an_prev;

            // Remote fault is a change event: its clearing edge counts as well.
            events[`PEIU_BIT_REM_FAULT] = (remote_fault != state_reg.rf_prev);
        end
    end

    // Link watch after negotiation completes. The timer only runs in the
    // wait state, and a restarted negotiation drops back to idle. Expiry
    // needs negotiation still done at that edge; a core that withdraws done
    // in the same cycle gets no report, which favours a quiet restart.
    always_comb
    begin
        no_link_hit = 1'b0;
        if (state_reg.armed && (state_reg.nl_state == peiu_pkg::PEIU_NL_WAIT)
            && !link_up && an_done && (state_reg.nl_timer >= NL_LIMIT))
        begin
            no_link_hit = 1'b1;
        end
    end

    // Next state of the control module.
    always_comb
    begin
        state_next = state_reg;

        // History follows the inputs every cycle, so the first armed edge
        // compares against what the inputs really were, not reset values.
        state_next.armed = 1'b1;
        state_next.speed_prev = speed_now;
        state_next.link_prev = link_up;
        state_next.duplex_prev = full_duplex;
        state_next.mdix_prev = mdix_swapped;
        state_next.pol_prev = rx_polarity;
        // Level faults keep their last value so only a new rise reports.
        state_next.pdf_prev = par_det_fault;
        state_next.msf_prev = ms_cfg_fault;
        state_next.nohcd_prev = no_common_ability;
        state_next.jab_prev = jabber_active;
        state_next.np_prev = next_page_rx;
        state_next.an_prev = an_done;
        state_next.rf_prev = remote_fault;

        case (state_reg.nl_state)
            peiu_pkg::PEIU_NL_IDLE:
            begin
                // Held at zero here so every wait counts up from zero.
                state_next.nl_timer = '0;
                if (state_reg.armed && an_done && !state_reg.an_prev)
                begin
                    state_next.nl_state = peiu_pkg::PEIU_NL_WAIT;
                end
            end

            peiu_pkg::PEIU_NL_WAIT:
            begin
                // Link up ends the watch quietly; expiry ends it with the flag.
                if (!an_done)
                begin
                    state_next.nl_state = peiu_pkg::PEIU_NL_IDLE;
                end
                else if (link_up || no_link_hit)
                begin
                    state_next.nl_state = peiu_pkg::PEIU_NL_HOLD;
                end
                else
                begin
                    state_next.nl_timer = state_reg.nl_timer + `PEIU_TIMER_W'(1);
                end
            end

            peiu_pkg::PEIU_NL_HOLD:
            begin
                // One report per negotiation; wait for the next one.
                if (!an_done)
                begin
                    state_next.nl_state = peiu_pkg::PEIU_NL_IDLE;
                end
            end

            // An illegal code from an upset returns to idle.
            default:
            begin
                state_next.nl_state = peiu_pkg::PEIU_NL_IDLE;
            end
        endcase

        // Register reads are answered one cycle after the request. Reads of
        // the flags show the word as it stands before this edge's updates.
        state_next.rd_valid = 1'b0;
        state_next.rd_data = `PEIU_READ_ZERO;
        if (mgmt_rd_en && (mgmt_addr == `PEIU_ADDR_STATUS))
        begin
            // Flags with the reserved bits forced to zero.
            state_next.rd_valid = 1'b1;
            state_next.rd_data = fif.flags & `PEIU_EVENT_BITS;
        end
        else if (mgmt_rd_en && (mgmt_addr == `PEIU_ADDR_MASK))
        begin
            // Enables read back as written, less the reserved bits.
            state_next.rd_valid = 1'b1;
            state_next.rd_data = fif.mask & `PEIU_EVENT_BITS;
        end
        else if (mgmt_rd_en && (mgmt_addr == `PEIU_ADDR_CLEAR))
        begin
            // The clear word returns to zero by itself, so it always reads zero.
            state_next.rd_valid = 1'b1;
            state_next.rd_data = `PEIU_READ_ZERO;
        end
        else
        begin
            // Other addresses belong to other register blocks.
            state_next.rd_valid = 1'b0;
            state_next.rd_data = `PEIU_READ_ZERO;
        end
    end

    // Registers the control state. The history resets to idle levels, but
    // the arming bit still hides the first edge, because the inputs need
    // not stand at those levels when reset ends.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.armed <= 1'b0;
            state_reg.speed_prev <= peiu_pkg::PEIU_SPEED_10;
            state_reg.link_prev <= 1'b0;
            state_reg.duplex_prev <= 1'b0;
            state_reg.mdix_prev <= 1'b0;
            state_reg.pol_prev <= 4'h0;
            state_reg.pdf_prev <= 1'b0;
            state_reg.msf_prev <= 1'b0;
            state_reg.nohcd_prev <= 1'b0;
            state_reg.jab_prev <= 1'b0;
            state_reg.np_prev <= 1'b0;
            state_reg.an_prev <= 1'b0;
            state_reg.rf_prev <= 1'b0;
            state_reg.nl_state <= peiu_pkg::PEIU_NL_IDLE;
            state_reg.nl_timer <= '0;
            state_reg.rd_data <= `PEIU_READ_ZERO;
            state_reg.rd_valid <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Connections to the flag bank.
    assign fif.event_set = events;
    assign fif.clear_req = clear_bits;
    assign fif.mask_we = mask_wr;
    // Raw write data is passed on; the bank drops the reserved bits itself.
    assign fif.mask_wdata = mgmt_wr_data;

    // Outputs. Read data and valid come straight from flops, and the
    // interrupt is the bank's own registered output.
    assign mgmt_rd_data = state_reg.rd_data;
    assign mgmt_rd_valid = state_reg.rd_valid;
    assign irq = fif.irq;

endmodule : peiu_top

// file: test/peiu_properties.sv
`timescale 1ns/100ps
`include "peiu_defines.svh"

// Watches the unit at its ports; a shadow of the enable word stands in for internals.
module peiu_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`PEIU_ADDR_W-1:0] mgmt_addr,
    input wire logic mgmt_wr_en,
    input wire logic [`PEIU_DATA_W-1:0] mgmt_wr_data,
    input wire logic mgmt_rd_en,
    input wire logic [`PEIU_DATA_W-1:0] mgmt_rd_data,
    input wire logic mgmt_rd_valid,
    input wire logic [1:0] link_speed,
    input wire logic link_up,
    input wire logic jabber_active,
    input wire logic irq
);
    logic live_reg;
    logic [`PEIU_DATA_W-1:0] mask_reg;
    logic rd_hit;
    logic mask_wr;

    // Decode of mapped reads and of enable word writes.
    assign rd_hit = mgmt_rd_en && (mgmt_addr == `PEIU_ADDR_STATUS ||
        mgmt_addr == `PEIU_ADDR_MASK || mgmt_addr == `PEIU_ADDR_CLEAR);
    assign mask_wr = mgmt_wr_en && mgmt_addr == `PEIU_ADDR_MASK;

    // Events count only from the second edge after reset, when input history is valid.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            live_reg <= 1'b0;
            mask_reg <= `PEIU_MASK_RESET;
        end
        else
        begin
            live_reg <= 1'b1;
            if (mask_wr)
            begin
                mask_reg <= mgmt_wr_data & `PEIU_EVENT_BITS;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_read_answered: assert property (rd_hit |=> mgmt_rd_valid)
        else $error("mapped read not answered");
    chk_read_refused: assert property (mgmt_rd_en && !rd_hit |=>
        !mgmt_rd_valid && mgmt_rd_data == 16'h0000) else $error("unmapped read answered");
    chk_clear_reads_zero: assert property (mgmt_rd_en && mgmt_addr == `PEIU_ADDR_CLEAR
        |=> mgmt_rd_data == 16'h0000) else $error("clear word read not zero");
    chk_reserved_zero: assert property (mgmt_rd_valid |-> mgmt_rd_data[2:0] == 3'h0)
        else $error("reserved bits read nonzero");
    chk_mask_readback: assert property (mgmt_rd_en && mgmt_addr == `PEIU_ADDR_MASK
        |=> mgmt_rd_data == $past(mask_reg)) else $error("enable word readback wrong");
    chk_irq_gated: assert property (irq |-> mask_reg != 16'h0000)
        else $error("irq with all events masked");
    chk_irq_holds: assert property (irq && !mask_wr &&
        !(mgmt_wr_en && mgmt_addr == `PEIU_ADDR_CLEAR) |=> irq) else $error("irq dropped");
    chk_speed_event: assert property (live_reg && $changed(link_speed) && mask_reg[15]
        && !mask_wr |=> irq) else $error("speed change gave no irq");
    chk_link_event: assert property (live_reg && $changed(link_up) && mask_reg[14]
        && !mask_wr |=> irq) else $error("link change gave no irq");
    chk_jabber_event: assert property (live_reg && $changed(jabber_active)
        && link_speed == 2'h0 && mask_reg[6] && !mask_wr |=> irq)
        else $error("jabber change gave no irq");
endmodule : peiu_properties

bind peiu_top peiu_properties u_peiu_properties (.clk(clk), .rst_n(rst_n),
    .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en), .mgmt_wr_data(mgmt_wr_data),
    .mgmt_rd_en(mgmt_rd_en), .mgmt_rd_data(mgmt_rd_data), .mgmt_rd_valid(mgmt_rd_valid),
    .link_speed(link_speed), .link_up(link_up), .jabber_active(jabber_active), .irq(irq));

// file: test/peiu_station_model.sv
`timescale 1ns/100ps
`include "peiu_defines.svh"

// Station side of the management port: one request per call, strobe held one cycle.
module peiu_station_model (
    input wire logic clk,
    output logic [`PEIU_ADDR_W-1:0] mgmt_addr,
    output logic mgmt_wr_en,
    output logic [`PEIU_DATA_W-1:0] mgmt_wr_data,
    output logic mgmt_rd_en,
    input wire logic [`PEIU_DATA_W-1:0] mgmt_rd_data,
    input wire logic mgmt_rd_valid
);
    // Quiet port at time zero.
    initial
    begin
        mgmt_addr = '0;
        mgmt_wr_en = 1'b0;
        mgmt_wr_data = '0;
        mgmt_rd_en = 1'b0;
    end

    // A clear is a plain write; its bits return to zero on their own, so none follows.
    task automatic write_reg(input logic [`PEIU_ADDR_W-1:0] addr,
        input logic [`PEIU_DATA_W-1:0] data);
        @(posedge clk);
        mgmt_addr <= addr;
        mgmt_wr_data <= data & `PEIU_EVENT_BITS;
        mgmt_wr_en <= 1'b1;
        @(posedge clk);
        mgmt_wr_en <= 1'b0;
        mgmt_addr <= ~addr; // Released lines carry the inverse, never a stale copy.
        mgmt_wr_data <= ~data;
        #1;
    endtask : write_reg

    // The answer stands for the one cycle after the taking edge.
    task automatic read_reg(input logic [`PEIU_ADDR_W-1:0] addr,
        output logic [`PEIU_DATA_W-1:0] data, output logic valid);
        @(posedge clk);
        mgmt_addr <= addr;
        mgmt_rd_en <= 1'b1;
        @(posedge clk);
        mgmt_rd_en <= 1'b0;
        mgmt_addr <= ~addr;
        #1;
        data = mgmt_rd_data;
        valid = mgmt_rd_valid;
    endtask : read_reg
endmodule : peiu_station_model

// file: test/phy_event_interrupt_unit_bench.sv
`timescale 1ns/100ps
`include "peiu_defines.svh"

// Events are driven as one packed word; each row toggles or pulses one input.
module phy_event_interrupt_unit_bench;
    localparam logic [0:13][15:0] PAT = {16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0200,
        16'h0040, 16'h0020, 16'h0010, 16'h0002, 16'h0008, 16'h0004, 16'h0002, 16'h0001,
        16'h0008};
    localparam logic [0:13][15:0] EXP = {
        16'h8000, 16'h4000, 16'h2000, 16'h1000, // Changes of state.
        16'h0800, 16'h0400, 16'h0200, 16'h0100, // Polarity and faults.
        16'h0090, 16'h0040, 16'h0020, 16'h0010, // Negotiation, with jabber at 10 Mb/s.
        16'h0008, 16'h0000}; // Remote fault; jabber is refused off 10 Mb/s.
    localparam logic [0:13][3:0] HOLD = 56'h22222111E21122;
    localparam logic [0:13][1:0] SPD = {12'h000, 2'h2, 12'h000, 2'h1};
    logic clk;
    logic rst_n;
    logic [15:0] stim;
    logic [`PEIU_ADDR_W-1:0] mgmt_addr;
    logic mgmt_wr_en;
    logic [`PEIU_DATA_W-1:0] mgmt_wr_data;
    logic mgmt_rd_en;
    logic [`PEIU_DATA_W-1:0] mgmt_rd_data;
    logic mgmt_rd_valid;
    logic irq;
    int num_errors;
    int check_count;

    // Short no-link wait keeps the run brief.
    peiu_top #(.NO_LINK_CYCLES(8)) u_peiu_top (.clk(clk), .rst_n(rst_n), .mgmt_addr(mgmt_addr),
        .mgmt_wr_en(mgmt_wr_en), .mgmt_wr_data(mgmt_wr_data), .mgmt_rd_en(mgmt_rd_en),
        .mgmt_rd_data(mgmt_rd_data), .mgmt_rd_valid(mgmt_rd_valid), .link_speed(stim[15:14]),
        .link_up(stim[13]), .full_duplex(stim[12]), .mdix_swapped(stim[11]),
        .rx_polarity(stim[10:7]), .par_det_fault(stim[6]), .ms_cfg_fault(stim[5]),
        .no_common_ability(stim[4]), .jabber_active(stim[3]), .next_page_rx(stim[2]),
        .an_done(stim[1]), .remote_fault(stim[0]), .irq(irq));
    peiu_station_model u_peiu_station_model (.clk(clk), .mgmt_addr(mgmt_addr),
        .mgmt_wr_en(mgmt_wr_en), .mgmt_wr_data(mgmt_wr_data), .mgmt_rd_en(mgmt_rd_en),
        .mgmt_rd_data(mgmt_rd_data), .mgmt_rd_valid(mgmt_rd_valid));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic irq_is(input logic e, input string what);
        check(what, {15'h0000, e}, {15'h0000, irq});
    endtask : irq_is

    task automatic wr(input logic [`PEIU_ADDR_W-1:0] a, input logic [15:0] d);
        u_peiu_station_model.write_reg(a, d);
    endtask : wr

    task automatic rd_check(input logic [`PEIU_ADDR_W-1:0] a, input logic [15:0] exp,
        input string what);
        logic [15:0] d;
        logic v;
        u_peiu_station_model.read_reg(a, d, v);
        check("read valid", 16'h0001, {15'h0000, v});
        check(what, exp, d);
    endtask : rd_check

    // Settle the speed, clear old flags, then apply one row's event and restore it.
    task automatic fire(input int k);
        @(posedge clk);
        stim <= {SPD[k], 14'h0000};
        tick(2);
        wr(`PEIU_ADDR_CLEAR, `PEIU_EVENT_BITS);
        @(posedge clk);
        stim <= {SPD[k], 14'h0000} ^ PAT[k];
        tick(int'(HOLD[k]));
        stim <= {SPD[k], 14'h0000};
        tick(3);
        #1;
    endtask : fire

    task automatic t_reset_values;
        rd_check(`PEIU_ADDR_STATUS, `PEIU_STATUS_RESET, "flags reset");
        rd_check(`PEIU_ADDR_MASK, `PEIU_MASK_RESET, "mask reset");
        rd_check(`PEIU_ADDR_CLEAR, 16'h0000, "clear word");
        irq_is(1'b0, "irq reset");
        $display("test reset_values done");
    endtask : t_reset_values

    task automatic t_refused;
        logic [15:0] d;
        logic v;
        u_peiu_station_model.read_reg(5'h16, d, v);
        check("unmapped valid", 16'h0000, {15'h0000, v});
        check("unmapped data", 16'h0000, d);
        fire(0);
        wr(`PEIU_ADDR_STATUS, `PEIU_EVENT_BITS);
        rd_check(`PEIU_ADDR_STATUS, 16'h8000, "read-only flags");
        $display("test refused done");
    endtask : t_refused

    task automatic t_mask_only;
        wr(`PEIU_ADDR_CLEAR, `PEIU_EVENT_BITS);
        wr(`PEIU_ADDR_MASK, 16'h8000);
        irq_is(1'b0, "mask without flag");
        wr(`PEIU_ADDR_MASK, `PEIU_EVENT_BITS);
        rd_check(`PEIU_ADDR_MASK, 16'hFFF8, "mask readback");
        wr(`PEIU_ADDR_MASK, 16'h0000);
        rd_check(`PEIU_ADDR_MASK, 16'h0000, "mask cleared");
        $display("test mask_only done");
    endtask : t_mask_only

    // Every event with its enable off, then on, then cleared.
    task automatic t_events;
        for (int k = 0; k < 14; k++)
        begin
            fire(k);
            rd_check(`PEIU_ADDR_STATUS, EXP[k], "event flags");
            irq_is(1'b0, "masked irq");
            wr(`PEIU_ADDR_MASK, EXP[k]);
            irq_is(EXP[k] != 16'h0000, "enabled irq");
            wr(`PEIU_ADDR_CLEAR, EXP[k]);
            irq_is(1'b0, "irq after clear");
            rd_check(`PEIU_ADDR_STATUS, 16'h0000, "flags after clear");
            wr(`PEIU_ADDR_MASK, 16'h0000);
        end
        $display("test events done");
    endtask : t_events

    // Events arriving while already enabled raise the interrupt directly.
    task automatic t_live_irq;
        wr(`PEIU_ADDR_MASK, `PEIU_EVENT_BITS);
        for (int i = 0; i < 3; i++)
        begin
            fire(i == 2 ? 9 : i);
            irq_is(1'b1, "live irq");
            wr(`PEIU_ADDR_CLEAR, `PEIU_EVENT_BITS);
            irq_is(1'b0, "irq cleared");
        end
        wr(`PEIU_ADDR_MASK, 16'h0000);
        $display("test live_irq done");
    endtask : t_live_irq

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // Free-running 125 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cuts a hang short; the tests need well under a tenth of this span.
    initial
    begin
        tick(20000);
        num_errors++;
        $display("watchdog expired");
        complete_run;
    end

    // Main sequence after an eight-cycle reset.
    initial
    begin
        num_errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        stim = 16'h0000;
        tick(8);
        rst_n <= 1'b1;
        tick(2);
        t_reset_values;
        t_refused;
        t_mask_only;
        t_events;
        t_live_irq;
        complete_run;
    end
endmodule : phy_event_interrupt_unit_bench
